// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
  import tci_pkg::*;
  logic         clk_i, rst_i, wr, rd, busy, pwait, pair, hit, ev_end, narrow;
  logic         hdr, mark, byp, lhit, ewv, trv;
  logic [15:0]  wdata, rdata, ew, r0, r1;
  logic [1:0]   r_edge, dead;
  logic [2:0]   r_lead, bufd;
  logic [3:0]   r_width, lim;
  logic [10:0]  errt;
  logic [31:0]  chan;
  logic [127:0] chip;
  int           errors, cmp_count, cyc;
  tci_host i_host (.clk_i(clk_i), .busy_i(busy), .param_wait_i(pwait), .rdata_i(rdata),
                   .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  tci_opcode_interp i_dut (.clk_i(clk_i), .rst_i(rst_i), .wr_i(wr), .rd_i(rd), .wdata_i(wdata),
    .rdata_o(rdata), .busy_o(busy), .param_wait_o(pwait), .narrow_i(narrow), .pair_mode_i(pair),
    .res_edge_i(r_edge), .res_lead_i(r_lead), .res_width_i(r_width), .hdr_trl_en_o(hdr),
    .err_mark_en_o(mark), .err_bypass_en_o(byp), .err_type_en_o(errt), .dead_time_o(dead),
    .hit_limit_o(lim), .buf_depth_o(bufd), .chan_enable_o(chan), .chip_enable_o(chip),
    .hit_i(hit), .event_end_i(ev_end), .limit_hit_o(lhit), .err_word_valid_o(ewv),
    .err_word_o(ew), .trailer_valid_o(trv));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Defaults straight out of reset
  task automatic t_reset;
    chk({hdr, mark, byp, dead, lim, bufd, errt}, {3'b010, 2'h0, 4'h9, 3'h7, 11'h7ff});
    chk({rdata, busy, pwait, lhit, ewv, ew, trv}, 37'h0);
    chk(chan, 32'hffffffff);
    chk(chip, {128{1'b1}});
    $display("reset defaults done");
  endtask
  // Each parameter opcode waits for its word, then reads back through its partner opcode
  task automatic t_params;
    logic [15:0] ops [4] = '{16'h2800, 16'h3300, 16'h3900, 16'h3b00};
    logic [15:0] rds [4] = '{16'h2900, 16'h3400, 16'h3a00, 16'h3c00};
    logic [15:0] val [4] = '{16'h0003, 16'h0001, 16'h0555, 16'h0000};
    for (int i = 0; i < 4; i++) begin
      i_host.put(ops[i]);
      chk(pwait, 1'b1);
      i_host.put(val[i]);
      chk(pwait, 1'b0);
      i_host.put(rds[i]);
      i_host.get(r0);
      chk(r0, val[i]);
    end
    chk({dead, lim, errt, bufd}, {2'h3, 4'h1, 11'h555, 3'h0});
    $display("parameter opcodes done");
  endtask
  // Flag opcodes take no word and leave the others alone
  task automatic t_flags;
    logic [15:0] ops [6] = '{16'h3000, 16'h3100, 16'h3600, 16'h3500, 16'h3700, 16'h3800};
    logic [2:0]  exp [6] = '{3'b110, 3'b010, 3'b000, 3'b010, 3'b011, 3'b010};
    for (int i = 0; i < 6; i++) begin
      i_host.put(ops[i]);
      chk({pwait, hdr, mark, byp}, {1'b0, exp[i]});
      if (i < 2) begin
        i_host.put(16'h3200);
        i_host.get(r0);
        chk(r0, {15'h0, exp[i][2]});
      end
    end
    $display("flag opcodes done");
  endtask
  // Resolution read in both detection modes
  task automatic t_res;
    pair = 1'b0;
    for (int e = 0; e < 4; e++) begin
      r_edge = e[1:0];
      i_host.put(16'h2600);
      i_host.get(r0);
      chk(r0, {14'h0, e[1:0]});
    end
    pair = 1'b1;
    i_host.put(16'h2600);
    i_host.get(r0);
    chk(r0, 16'h0d05);
    {r_lead, r_width} = {3'h2, 4'h7};
    i_host.put(16'h2600);
    i_host.get(r0);
    chk(r0, 16'h0702);
    pair = 1'b0;
    $display("resolution read done");
  endtask
  // Channel masks, single and all while hits keep arriving, then board and chip patterns
  task automatic t_chan;
    hit = 1'b1;
    i_host.put(16'h4105);
    chk(chan, 32'hffffffdf);
    i_host.put(16'h4005);
    i_host.put(16'h411f);
    i_host.put(16'h4120);
    chk(chan, 32'h7fffffff);
    i_host.put(16'h4300);
    chk(chan, 32'h0);
    i_host.put(16'h4200);
    chk(chan, 32'hffffffff);
    hit = 1'b0;
    i_host.put(16'h4400);
    i_host.put(16'h1234);
    i_host.put(16'habcd);
    chk({pwait, chan}, {1'b0, 32'habcd1234});
    i_host.put(16'h4500);
    i_host.get(r0);
    i_host.get(r1);
    chk({r1, r0}, 32'habcd1234);
    i_host.put(16'h4602);
    i_host.put(16'h1111);
    i_host.put(16'h2222);
    chk({chip[127:96], chip[95:64], chip[63:0]}, {32'hffffffff, 32'h22221111, 64'hffffffffffffffff});
    i_host.put(16'h4702);
    i_host.get(r0);
    i_host.get(r1);
    chk({pwait, r1, r0}, {1'b0, 32'h22221111});
    $display("channel masks done");
  endtask
  // Sixteen-channel variant: one mask word, upper channels out of reach
  task automatic t_narrow;
    narrow = 1'b1;
    i_host.put(16'h4110);
    chk(chan, 32'h00001234);
    i_host.put(16'h4400);
    i_host.put(16'h5678);
    chk({pwait, chan}, {1'b0, 32'h00005678});
    i_host.put(16'h4500);
    i_host.put(16'h4300);
    i_host.get(r0);
    chk({pwait, r0, chan}, {1'b0, 16'h5678, 32'h00005678});
    i_host.put(16'h5000);
    chk(pwait, 1'b0);
    narrow = 1'b0;
    @(negedge clk_i);
    chk(chan, 32'habcd5678);
    $display("narrow variant done");
  endtask
  // Limit of one hit, two hits arrive: error word then trailer
  task automatic t_hit;
    i_host.put(16'h3000);
    i_host.put(16'h3300);
    i_host.put(16'h0001);
    // Close the event left open by the channel test before counting afresh
    @(negedge clk_i) ev_end = 1'b1;
    @(negedge clk_i) ev_end = 1'b0;
    @(negedge clk_i);
    chk(lhit, 1'b0);
    hit = 1'b1;
    @(negedge clk_i);
    chk(lhit, 1'b0);
    @(negedge clk_i) hit = 1'b0;
    ev_end = 1'b1;
    chk(lhit, 1'b1);
    @(negedge clk_i) ev_end = 1'b0;
    chk({ewv, ew, trv}, {1'b1, 16'h1000, 1'b0});
    @(negedge clk_i);
    chk({ewv, trv}, 2'b01);
    $display("hit limit done");
  endtask
  // Cut a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      $display("BAD %0t timeout", $time);
      end_of_test;
    end
  end
  initial begin
    {rst_i, pair, hit, ev_end, narrow} = 5'b10000;
    {r_edge, r_lead, r_width} = {2'h0, 3'h5, 4'hd};
    repeat (6) @(posedge clk_i);
    @(negedge clk_i) rst_i = 1'b0;
    t_reset;
    t_params;
    t_flags;
    t_res;
    t_chan;
    t_narrow;
    t_hit;
    end_of_test;
  end
endmodule

// *** bench/tci_host.sv ***
`timescale 1ns/1ps
// Host software model: opcodes and parameter words share one 16-bit port
module tci_host (
  input  wire logic        clk_i,
  input  wire logic        busy_i,
  input  wire logic        param_wait_i,
  input  wire logic [15:0] rdata_i,
  output logic             wr_o,
  output logic             rd_o,
  output logic [15:0]      wdata_o
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 16'h0000;
  end
  // One word, one-cycle strobe, always at the same port
  task automatic put(input logic [15:0] w);
    @(negedge clk_i);
    wr_o = 1'b1;
    wdata_o = w;
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~w; // Released data must not keep its last value
  endtask
  // Pop a word once waiting and not fetching, or anyway after 20 cycles; every word is taken
  task automatic get(output logic [15:0] w);
    int n;
    n = 0;
    @(negedge clk_i);
    while ((busy_i !== 1'b0 || param_wait_i !== 1'b1) && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    // A wait that never ends hands back unknown, so the compare fails
    w = (n < 20) ? rdata_i : 'x;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
  endtask
endmodule

// *** rtl/tci_hit_limit.sv ***
`timescale 1ns/1ps
`include "tci_params.svh"
module tci_hit_limit (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  hit_limit_i,
  input  wire logic        hdr_trl_en_i,
  input  wire logic        hit_i,
  input  wire logic        event_end_i,
  output logic             limit_hit_o,
  output logic             err_word_valid_o,
  output logic [15:0]      err_word_o,
  output logic             trailer_valid_o
);
  typedef struct packed {
    logic [8:0]  hits;
    logic        over;
    logic        err_v;
    logic [15:0] err_word;
    logic        trl_v;
    logic        pend_trl;
  } tci_lim_t;
  tci_lim_t lim_reg;
  tci_lim_t lim_next;
  logic     limited;
  logic     over_now;
  logic [8:0] lim_val;

  // Code 0 allows none, 1..8 allow 2^(code-1); 9 and meaningless codes do not limit
  assign limited  = (hit_limit_i < `TCI_LIM_NONE);
  assign lim_val  = (hit_limit_i == 4'h0) ? 9'h000 : 9'(9'h001 << (hit_limit_i - 4'h1));
  assign over_now = lim_reg.over | (hit_i & limited & (lim_reg.hits >= lim_val));

  // Error word goes out first, the trailer follows it when enabled
  always_comb begin
    lim_next          = lim_reg;
    lim_next.err_v    = 1'b0;
    lim_next.err_word = 16'h0000;
    lim_next.trl_v    = lim_reg.pend_trl;
    lim_next.pend_trl = 1'b0;
    if (hit_i && lim_reg.hits != 9'h1ff) lim_next.hits = lim_reg.hits + 9'h001;
    lim_next.over = over_now;
    if (event_end_i) begin
      lim_next.hits     = 9'h000;
      lim_next.over     = 1'b0;
      lim_next.err_v    = over_now;                            // [RULE8]
      lim_next.err_word = over_now ? `TCI_ERR_FLAG : 16'h0000; // [RULE8]
      lim_next.pend_trl = over_now & hdr_trl_en_i;             // [RULE8]
      lim_next.trl_v    = ~over_now & hdr_trl_en_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lim_reg <= '0;
    end else begin
      lim_reg <= lim_next;
    end
  end

  assign limit_hit_o      = lim_reg.over;
  assign err_word_valid_o = lim_reg.err_v;
  assign err_word_o       = lim_reg.err_word;
  assign trailer_valid_o  = lim_reg.trl_v;

  property p_err_then_trl;
    @(posedge clk_i) disable iff (rst_i)
    (event_end_i && over_now && hdr_trl_en_i) |=> err_word_valid_o && !trailer_valid_o ##1 trailer_valid_o;
  endproperty
  a_err_then_trl: assert property (p_err_then_trl) else $error("Error word not before trailer"); // [RULE8]
endmodule

// *** rtl/tci_mask_mem.sv ***
`timescale 1ns/1ps
`include "tci_params.svh"
module tci_mask_mem
  import tci_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  tci_mem_if.mem    mif
);
  typedef struct packed {
    logic [15:0][15:0] words;
    logic [15:0]       rdata;
  } tci_mem_t;
  tci_mem_t          mem_reg;
  tci_mem_t          mem_next;
  logic [15:0][15:0] word_next;

  // Per-word update; bit ops act only on the board mask in words 0 and 1
  for (genvar i = 0; i < 16; i++) begin : g_word
    always_comb begin
      word_next[i] = mem_reg.words[i];
      unique case (mif.op)
        TCI_MOP_WRITE:  if (mif.addr == 4'(i)) word_next[i] = mif.wdata;
        TCI_MOP_SETBIT: if (i == 32'(mif.bitn[4])) word_next[i][mif.bitn[3:0]] = 1'b1;
        TCI_MOP_CLRBIT: if (i == 32'(mif.bitn[4])) word_next[i][mif.bitn[3:0]] = 1'b0;
        TCI_MOP_SETALL: if (i < 2) word_next[i] = 16'hffff;
        TCI_MOP_CLRALL: if (i < 2) word_next[i] = 16'h0000;
        TCI_MOP_NONE:   ;
        default:        ;
      endcase
    end
  end

  // Read port is registered: data for an address shows one cycle later
  always_comb begin
    mem_next       = mem_reg;
    mem_next.words = word_next;
    mem_next.rdata = mem_reg.words[mif.addr];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_reg <= {{16{`TCI_RST_MASK}}, 16'h0000};
    end else begin
      mem_reg <= mem_next;
    end
  end

  assign mif.rdata = mem_reg.rdata;
  assign mif.words = mem_reg.words;

  property p_setall;
    @(posedge clk_i) disable iff (rst_i)
    (mif.op == TCI_MOP_SETALL) |=> (mif.words[0] == 16'hffff) && (mif.words[1] == 16'hffff);
  endproperty
  a_setall: assert property (p_setall) else $error("Set-all did not fill board mask"); // [RULE18]
endmodule

// *** rtl/tci_mem_if.sv ***
`timescale 1ns/1ps
interface tci_mem_if;
  import tci_pkg::*;
  tci_mop_t          op;
  logic [3:0]        addr;
  logic [15:0]       wdata;
  logic [4:0]        bitn;
  logic [15:0]       rdata;
  logic [15:0][15:0] words;
  modport ctrl (output op, addr, wdata, bitn, input rdata, words);
  modport mem  (input op, addr, wdata, bitn, output rdata, words);
endinterface

// *** rtl/tci_opcode_interp.sv ***
// How it works
// (RULE1) Parameter opcodes wait for all their words
// (RULE2) 26xx edge mode returns two-bit resolution
// (RULE3) 26xx pair mode returns lead and width
// (RULE4) 28xx sets dead time, 29xx reads it
// (RULE5) 30xx/31xx switch header and trailer insertion
// (RULE6) 32xx returns header/trailer enable in bit 0
// (RULE7) 33xx sets the per-event hit limit
// (RULE8) Overflow appends error word before trailer
// (RULE9) 34xx returns the hit limit code
// (RULE10) 35xx/36xx switch error marking on/off
// (RULE11) 37xx/38xx switch bypass on global error
// (RULE12) 39xx sets eleven error-type enables
// (RULE13) 3Axx returns the error-type enables
// (RULE14) 3Bxx sets first-level buffer depth code
// (RULE15) 3Cxx returns the buffer depth code
// (RULE16) Channel opcodes work during acquisition too
// (RULE17) 40nn/41nn enable/disable one channel
// (RULE18) 42xx/43xx enable/disable all channels
// (RULE19) 44xx writes board mask, one or two words
// (RULE20) 45xx reads board mask, same mapping
// (RULE21) 460n writes chip n's 32-channel mask
// (RULE22) 470n reads chip n's mask, two words
// (RULE23) Host uses this one port for parameters
// (RULE24) Upper byte is command, lower byte index
`timescale 1ns/1ps
`include "tci_params.svh"
module tci_opcode_interp
  import tci_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [15:0] wdata_i,
  output logic [15:0]      rdata_o,
  output logic             busy_o,
  output logic             param_wait_o,
  input  wire logic        narrow_i,
  input  wire logic        pair_mode_i,
  input  wire logic [1:0]  res_edge_i,
  input  wire logic [2:0]  res_lead_i,
  input  wire logic [3:0]  res_width_i,
  output logic             hdr_trl_en_o,
  output logic             err_mark_en_o,
  output logic             err_bypass_en_o,
  output logic [10:0]      err_type_en_o,
  output logic [1:0]       dead_time_o,
  output logic [3:0]       hit_limit_o,
  output logic [2:0]       buf_depth_o,
  output logic [31:0]      chan_enable_o,
  output logic [127:0]     chip_enable_o,
  input  wire logic        hit_i,
  input  wire logic        event_end_i,
  output logic             limit_hit_o,
  output logic             err_word_valid_o,
  output logic [15:0]      err_word_o,
  output logic             trailer_valid_o
);
  tci_main_t  r_reg;
  tci_main_t  r_next;
  tci_mem_if  mif ();
  logic [7:0] op_cmd;
  logic [7:0] op_idx;
  logic [3:0] base;
  logic       is_mask;
  logic [7:0] chan_lim;

  // Upper byte selects the command, lower byte is the index
  assign op_cmd   = wdata_i[15:8]; // [RULE24]
  assign op_idx   = wdata_i[7:0];  // [RULE24]
  assign chan_lim = narrow_i ? `TCI_CHAN_NARROW : `TCI_CHAN_N;

  // Mask words live at 0..1 for the board and two per chip above that
  assign is_mask = (r_reg.cmd == `TCI_OP_RD_CHIP) || (r_reg.cmd == `TCI_OP_WR_CHIP);
  assign base    = is_mask ? 4'(`TCI_CHIP_BASE + {r_reg.idx[1:0], 1'b0}) : 4'h0;

  tci_mask_mem u_mem (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .mif   (mif.mem)
  );

  tci_hit_limit u_lim (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .hit_limit_i      (r_reg.hit_lim),
    .hdr_trl_en_i     (r_reg.hdr_trl),
    .hit_i            (hit_i),
    .event_end_i      (event_end_i),
    .limit_hit_o      (limit_hit_o),
    .err_word_valid_o (err_word_valid_o),
    .err_word_o       (err_word_o),
    .trailer_valid_o  (trailer_valid_o)
  );

  // Command sequencer; no acquisition gating, so channel ops apply at once
  always_comb begin
    r_next    = r_reg;
    mif.op    = TCI_MOP_NONE;
    mif.addr  = 4'(base + {3'h0, r_reg.wsel});
    mif.wdata = wdata_i;
    mif.bitn  = op_idx[4:0];
    unique case (r_reg.state)
      TCI_IDLE: begin
        if (wr_i) begin
          r_next.cmd  = op_cmd;
          r_next.idx  = op_idx;
          r_next.wsel = 1'b0;
          r_next.left = 2'h1;
          case (op_cmd)
            `TCI_OP_RD_RES: begin
              r_next.state = TCI_WAIT_RD;
              if (pair_mode_i) begin
                r_next.rdata = {4'h0, res_width_i, 5'h00, res_lead_i}; // [RULE3]
              end else begin
                r_next.rdata = {14'h0000, res_edge_i};                 // [RULE2]
              end
            end
            `TCI_OP_RD_DEAD: begin
              r_next.state = TCI_WAIT_RD;
              r_next.rdata = {14'h0000, r_reg.dead};     // [RULE4]
            end
            `TCI_OP_RD_HT: begin
              r_next.state = TCI_WAIT_RD;
              r_next.rdata = {15'h0000, r_reg.hdr_trl};  // [RULE6]
            end
            `TCI_OP_RD_LIM: begin
              r_next.state = TCI_WAIT_RD;
              r_next.rdata = {12'h000, r_reg.hit_lim};   // [RULE9]
            end
            `TCI_OP_RD_ERRT: begin
              r_next.state = TCI_WAIT_RD;
              r_next.rdata = {5'h00, r_reg.err_type};    // [RULE13]
            end
            `TCI_OP_RD_BUF: begin
              r_next.state = TCI_WAIT_RD;
              r_next.rdata = {13'h0000, r_reg.buf_depth}; // [RULE15]
            end
            `TCI_OP_WR_DEAD, `TCI_OP_WR_LIM, `TCI_OP_WR_ERRT, `TCI_OP_WR_BUF: begin
              r_next.state = TCI_WAIT_WR; // [RULE1]
            end
            `TCI_OP_HT_ON:    r_next.hdr_trl  = 1'b1; // [RULE5]
            `TCI_OP_HT_OFF:   r_next.hdr_trl  = 1'b0; // [RULE5]
            `TCI_OP_MARK_ON:  r_next.err_mark = 1'b1; // [RULE10]
            `TCI_OP_MARK_OFF: r_next.err_mark = 1'b0; // [RULE10]
            `TCI_OP_BYP_ON:   r_next.bypass   = 1'b1; // [RULE11]
            `TCI_OP_BYP_OFF:  r_next.bypass   = 1'b0; // [RULE11]
            `TCI_OP_CH_ON: begin
              if (op_idx < chan_lim) mif.op = TCI_MOP_SETBIT; // [RULE17] [RULE16]
            end
            `TCI_OP_CH_OFF: begin
              if (op_idx < chan_lim) mif.op = TCI_MOP_CLRBIT; // [RULE17] [RULE16]
            end
            `TCI_OP_ALL_ON:  mif.op = TCI_MOP_SETALL; // [RULE18]
            `TCI_OP_ALL_OFF: mif.op = TCI_MOP_CLRALL; // [RULE18]
            `TCI_OP_WR_MASK: begin
              r_next.state = TCI_WAIT_WR;
              r_next.left  = narrow_i ? 2'h1 : 2'h2; // [RULE19]
            end
            `TCI_OP_WR_CHIP: begin
              r_next.state = TCI_WAIT_WR;
              r_next.left  = 2'h2; // [RULE21]
            end
            `TCI_OP_RD_MASK: begin
              r_next.state = TCI_FETCH;
              r_next.left  = narrow_i ? 2'h1 : 2'h2; // [RULE20]
            end
            `TCI_OP_RD_CHIP: begin
              r_next.state = TCI_FETCH;
              r_next.left  = 2'h2; // [RULE22]
            end
            default: ; // Unknown commands are dropped without a wait
          endcase
        end
      end
      TCI_WAIT_WR: begin
        // Every word here is a parameter, never a new opcode
        if (wr_i) begin
          case (r_reg.cmd)
            `TCI_OP_WR_DEAD: r_next.dead      = wdata_i[1:0];  // [RULE4]
            `TCI_OP_WR_LIM:  r_next.hit_lim   = wdata_i[3:0];  // [RULE7]
            `TCI_OP_WR_ERRT: r_next.err_type  = wdata_i[10:0]; // [RULE12]
            `TCI_OP_WR_BUF:  r_next.buf_depth = wdata_i[2:0];  // [RULE14]
            `TCI_OP_WR_MASK, `TCI_OP_WR_CHIP: mif.op = TCI_MOP_WRITE; // [RULE19] [RULE21]
            default: ;
          endcase
          r_next.left = r_reg.left - 2'h1; // [RULE1]
          r_next.wsel = 1'b1;
          if (r_reg.left == 2'h1) r_next.state = TCI_IDLE;
        end
      end
      TCI_FETCH: begin
        // Memory read data arrives a cycle after the address
        r_next.state = TCI_LOAD;
      end
      TCI_LOAD: begin
        r_next.rdata = mif.rdata; // [RULE20] [RULE22]
        r_next.state = TCI_WAIT_RD;
      end
      TCI_WAIT_RD: begin
        if (rd_i) begin
          r_next.left = r_reg.left - 2'h1; // [RULE1]
          r_next.wsel = 1'b1;
          if (r_reg.left == 2'h1) begin
            r_next.state = TCI_IDLE;
          end else begin
            r_next.state = TCI_FETCH;
          end
        end
      end
      default: r_next.state = TCI_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg           <= '0;
      r_reg.state     <= TCI_IDLE;
      r_reg.hdr_trl   <= `TCI_RST_HT;
      r_reg.err_mark  <= `TCI_RST_MARK;
      r_reg.bypass    <= `TCI_RST_BYP;
      r_reg.err_type  <= `TCI_RST_ERRT;
      r_reg.dead      <= `TCI_RST_DEAD;
      r_reg.hit_lim   <= `TCI_RST_LIM;
      r_reg.buf_depth <= `TCI_RST_BUF;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from state; the 16-channel variant hides the upper half
  assign rdata_o         = r_reg.rdata;
  assign busy_o          = (r_reg.state == TCI_FETCH) || (r_reg.state == TCI_LOAD);
  assign param_wait_o    = (r_reg.state != TCI_IDLE);
  assign hdr_trl_en_o    = r_reg.hdr_trl;
  assign err_mark_en_o   = r_reg.err_mark;
  assign err_bypass_en_o = r_reg.bypass;
  assign err_type_en_o   = r_reg.err_type;
  assign dead_time_o     = r_reg.dead;
  assign hit_limit_o     = r_reg.hit_lim;
  assign buf_depth_o     = r_reg.buf_depth;
  assign chan_enable_o   = narrow_i ? {16'h0000, mif.words[0]} : {mif.words[1], mif.words[0]};
  assign chip_enable_o   = mif.words[9:2];

  // Helper: an opcode is taken only in the idle state
  logic idle_op;
  assign idle_op = wr_i && (r_reg.state == TCI_IDLE);

  property p_wait_wr_hold;
    @(posedge clk_i) disable iff (rst_i)
    (r_reg.state == TCI_WAIT_WR && !wr_i) |=> (r_reg.state == TCI_WAIT_WR) && $stable(r_reg.left);
  endproperty
  a_wait_wr_hold: assert property (p_wait_wr_hold) else $error("Left write wait early"); // [RULE1]

  property p_wait_rd_hold;
    @(posedge clk_i) disable iff (rst_i)
    (r_reg.state == TCI_WAIT_RD && !rd_i) |=> (r_reg.state == TCI_WAIT_RD) && $stable(rdata_o);
  endproperty
  a_wait_rd_hold: assert property (p_wait_rd_hold) else $error("Left read wait early"); // [RULE1]

  property p_res_edge;
    @(posedge clk_i) disable iff (rst_i)
    (idle_op && op_cmd == `TCI_OP_RD_RES && !pair_mode_i) |=> (rdata_o == {14'h0000, $past(res_edge_i)});
  endproperty
  a_res_edge: assert property (p_res_edge) else $error("Edge resolution word wrong"); // [RULE2]

  property p_res_pair;
    @(posedge clk_i) disable iff (rst_i)
    (idle_op && op_cmd == `TCI_OP_RD_RES && pair_mode_i) |=>
      (rdata_o[2:0] == $past(res_lead_i)) && (rdata_o[11:8] == $past(res_width_i));
  endproperty
  a_res_pair: assert property (p_res_pair) else $error("Pair resolution word wrong"); // [RULE3]

  property p_dead_set;
    @(posedge clk_i) disable iff (rst_i)
    (r_reg.state == TCI_WAIT_WR && r_reg.cmd == `TCI_OP_WR_DEAD && wr_i) |=>
      (dead_time_o == $past(wdata_i[1:0])) && !param_wait_o;
  endproperty
  a_dead_set: assert property (p_dead_set) else $error("Dead time not taken"); // [RULE4]

  property p_ht_read;
    @(posedge clk_i) disable iff (rst_i)
    (idle_op && op_cmd == `TCI_OP_HT_ON) ##1 !wr_i ##1 (idle_op && op_cmd == `TCI_OP_RD_HT) |=>
      (rdata_o == 16'h0001);
  endproperty
  a_ht_read: assert property (p_ht_read) else $error("Header/trailer status wrong"); // [RULE6]

  property p_lim_set;
    @(posedge clk_i) disable iff (rst_i)
    (r_reg.state == TCI_WAIT_WR && r_reg.cmd == `TCI_OP_WR_LIM && wr_i) |=> (hit_limit_o == $past(wdata_i[3:0]));
  endproperty
  a_lim_set: assert property (p_lim_set) else $error("Hit limit not taken"); // [RULE7]

  property p_buf_set;
    @(posedge clk_i) disable iff (rst_i)
    (r_reg.state == TCI_WAIT_WR && r_reg.cmd == `TCI_OP_WR_BUF && wr_i) |=> (buf_depth_o == $past(wdata_i[2:0]));
  endproperty
  a_buf_set: assert property (p_buf_set) else $error("Buffer depth not taken"); // [RULE14]

  property p_chan_on;
    @(posedge clk_i) disable iff (rst_i)
    (idle_op && op_cmd == `TCI_OP_CH_ON && op_idx < chan_lim) |=> chan_enable_o[$past(wdata_i[4:0])];
  endproperty
  a_chan_on: assert property (p_chan_on) else $error("Channel not enabled"); // [RULE17]

  property p_all_off;
    @(posedge clk_i) disable iff (rst_i)
    (idle_op && op_cmd == `TCI_OP_ALL_OFF) |=> (chan_enable_o == 32'h00000000);
  endproperty
  a_all_off: assert property (p_all_off) else $error("Channels not all disabled"); // [RULE18]

  property p_mask_rd;
    @(posedge clk_i) disable iff (rst_i)
    (idle_op && op_cmd == `TCI_OP_RD_MASK) |=> busy_o [*2] ##1 (!busy_o && rdata_o == chan_enable_o[15:0]);
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("Mask word 0 read wrong"); // [RULE20]

  property p_chip_words;
    @(posedge clk_i) disable iff (rst_i)
    // The first chip mask word must never end the wait
    (r_reg.state == TCI_WAIT_WR && r_reg.cmd == `TCI_OP_WR_CHIP && r_reg.left == 2'h2 && wr_i) |=>
      param_wait_o;
  endproperty
  a_chip_words: assert property (p_chip_words) else $error("Chip mask wait too short"); // [RULE21]
endmodule

// *** rtl/tci_params.svh ***
`ifndef TCI_PARAMS_SVH
`define TCI_PARAMS_SVH
// Command codes, upper byte of an opcode
`define TCI_OP_RD_RES   8'h26
`define TCI_OP_WR_DEAD  8'h28
`define TCI_OP_RD_DEAD  8'h29
`define TCI_OP_HT_ON    8'h30
`define TCI_OP_HT_OFF   8'h31
`define TCI_OP_RD_HT    8'h32
`define TCI_OP_WR_LIM   8'h33
`define TCI_OP_RD_LIM   8'h34
`define TCI_OP_MARK_ON  8'h35
`define TCI_OP_MARK_OFF 8'h36
`define TCI_OP_BYP_ON   8'h37
`define TCI_OP_BYP_OFF  8'h38
`define TCI_OP_WR_ERRT  8'h39
`define TCI_OP_RD_ERRT  8'h3a
`define TCI_OP_WR_BUF   8'h3b
`define TCI_OP_RD_BUF   8'h3c
`define TCI_OP_CH_ON    8'h40
`define TCI_OP_CH_OFF   8'h41
`define TCI_OP_ALL_ON   8'h42
`define TCI_OP_ALL_OFF  8'h43
`define TCI_OP_WR_MASK  8'h44
`define TCI_OP_RD_MASK  8'h45
`define TCI_OP_WR_CHIP  8'h46
`define TCI_OP_RD_CHIP  8'h47
// Reset values
`define TCI_RST_DEAD    2'h0
`define TCI_RST_LIM     4'h9
`define TCI_RST_BUF     3'h7
`define TCI_RST_HT      1'h0
`define TCI_RST_MARK    1'h1
`define TCI_RST_BYP     1'h0
`define TCI_RST_ERRT    11'h7ff
`define TCI_RST_MASK    16'hffff
// Fields and constants
`define TCI_LIM_NONE    4'h9
`define TCI_ERR_FLAG    16'h1000
`define TCI_CHIP_BASE   4'h2
`define TCI_CHAN_N      8'h20
`define TCI_CHAN_NARROW 8'h10
`endif

// *** rtl/tci_pkg.sv ***
package tci_pkg;
  typedef enum logic [2:0] {
    TCI_IDLE    = 3'b000,
    TCI_FETCH   = 3'b001,
    TCI_LOAD    = 3'b010,
    TCI_WAIT_RD = 3'b011,
    TCI_WAIT_WR = 3'b100
  } tci_state_t;
  typedef enum logic [2:0] {
    TCI_MOP_NONE   = 3'b000,
    TCI_MOP_WRITE  = 3'b001,
    TCI_MOP_SETBIT = 3'b010,
    TCI_MOP_CLRBIT = 3'b011,
    TCI_MOP_SETALL = 3'b100,
    TCI_MOP_CLRALL = 3'b101
  } tci_mop_t;
  typedef struct packed {
    tci_state_t  state;
    logic [7:0]  cmd;
    logic [7:0]  idx;
    logic [1:0]  left;
    logic        wsel;
    logic [15:0] rdata;
    logic        hdr_trl;
    logic        err_mark;
    logic        bypass;
    logic [10:0] err_type;
    logic [1:0]  dead;
    logic [3:0]  hit_lim;
    logic [2:0]  buf_depth;
  } tci_main_t;
endpackage
